// *** core_config_capability_regs.sv ***
// core configuration, capability and linked-load address registers
`timescale 1ns/10ps
module core_config_capability_regs #(
  parameter logic [1:0] ARCH_TYPE      = 2'h2,
  parameter logic [2:0] ARCH_REVISION  = 3'h0,
  parameter logic [2:0] MMU_KIND       = 3'h1,
  parameter logic [5:0] TLB_MINUS_ONE  = 6'h1f,
  parameter logic [2:0] ICACHE_SETS    = 3'h2,
  parameter logic [2:0] ICACHE_LINE    = 3'h4,
  parameter logic [2:0] ICACHE_WAYS    = 3'h1,
  parameter logic [2:0] DCACHE_SETS    = 3'h2,
  parameter logic [2:0] DCACHE_LINE    = 3'h4,
  parameter logic [2:0] DCACHE_WAYS    = 3'h1,
  parameter logic       HAS_PERF       = 1'b0,
  parameter logic       HAS_WATCH      = 1'b1,
  parameter logic       HAS_COMPRESSED = 1'b0,
  parameter logic       HAS_DEBUG_PORT = 1'b0,
  parameter logic       HAS_FLOAT      = 1'b1,
  parameter logic [2:0] WATCH_IMPL     = 3'h3
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // external strap
  input  wire logic              byte_order_flag,
  // coprocessor moves
  input  wire cfg_pkg::move_req_t move_req,
  output logic [63:0]            move_rdata,
  // linked load capture
  input  wire logic              ll_valid,
  input  wire logic [63:0]       ll_paddr,
  // watch exception handling
  input  wire logic              watch_hit,
  input  wire logic              exception_level_bit,
  input  wire logic              error_level_bit,
  input  wire logic              deferred_clear,
  output logic                   watch_exception,
  output logic                   deferred_flag,
  // coherency out to cache logic
  output logic [2:0]             kernel_segment_coherency
);
  logic [2:0]  k0_next;
  logic [63:0] linked_load_address_reg, linked_load_address_next;
  logic [63:0] rdata_next;
  logic        order_reg;
  logic [31:0] main_word;
  logic [31:0] cap_word;
  logic [2:0]  watch_en;
  logic        watch_we;
  logic        exc_int;
  logic        defer_int;
  logic        defer_reg;

  // ==========================================================
  // read-back words, read-only except the k0 field of the main word
  always_comb
  begin
    main_word = 32'h0;
    main_word[cfg_pkg::cfg_more_bit] = 1'b1;
    main_word[cfg_pkg::cfg_order_bit] = order_reg;
    main_word[cfg_pkg::cfg_at_lsb +: 2] = ARCH_TYPE;
    main_word[cfg_pkg::cfg_ar_lsb +: 3] = ARCH_REVISION;
    main_word[cfg_pkg::cfg_mt_lsb +: 3] = MMU_KIND;
    main_word[cfg_pkg::cfg_k0_lsb +: 3] = kernel_segment_coherency;
  end

  always_comb
  begin
    cap_word = 32'h0;
    cap_word[cfg_pkg::cap_tlb_lsb +: 6] =
      (MMU_KIND == cfg_pkg::mmu_none) ? 6'h0 : TLB_MINUS_ONE;
    cap_word[cfg_pkg::cap_is_lsb +: 3] = ICACHE_SETS;
    cap_word[cfg_pkg::cap_ds_lsb +: 3] = DCACHE_SETS;
    cap_word[cfg_pkg::cap_il_lsb +: 3] = ICACHE_LINE;
    cap_word[cfg_pkg::cap_dl_lsb +: 3] = DCACHE_LINE;
    cap_word[cfg_pkg::cap_ia_lsb +: 3] = ICACHE_WAYS;
    cap_word[cfg_pkg::cap_da_lsb +: 3] = DCACHE_WAYS;
    cap_word[cfg_pkg::cap_pc_bit] = HAS_PERF;
    cap_word[cfg_pkg::cap_wr_bit] = HAS_WATCH;
    cap_word[cfg_pkg::cap_ca_bit] = HAS_COMPRESSED;
    cap_word[cfg_pkg::cap_ep_bit] = HAS_DEBUG_PORT;
    cap_word[cfg_pkg::cap_fp_bit] = HAS_FLOAT;
  end

  // ==========================================================
  // writes and capture
  always_comb
  begin
    k0_next = kernel_segment_coherency;
    if (move_req.wr && move_req.num == cfg_pkg::reg_num_config &&
        move_req.sel == cfg_pkg::sel_main)
      k0_next = move_req.wdata[cfg_pkg::cfg_k0_lsb +: 3];
    linked_load_address_next = linked_load_address_reg;
    if (ll_valid)
      linked_load_address_next = ll_paddr;
  end

  assign watch_we = move_req.wr && HAS_WATCH &&
                    move_req.num == cfg_pkg::reg_num_watch_address_low;

  // ==========================================================
  // read mux
  always_comb
  begin
    rdata_next = 64'h0;
    if (move_req.rd)
    begin
      case (move_req.num)
        cfg_pkg::reg_num_config:
        begin
          if (move_req.sel == cfg_pkg::sel_main)
            rdata_next = {32'h0, main_word};
          else if (move_req.sel == cfg_pkg::sel_capability)
            rdata_next = {32'h0, cap_word};
          else
            rdata_next = 64'h0;
        end
        cfg_pkg::reg_num_linked_load_address: rdata_next = linked_load_address_reg;
        cfg_pkg::reg_num_watch_address_low:
          rdata_next = {61'h0, watch_en};
        default: rdata_next = 64'h0;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      kernel_segment_coherency <= cfg_pkg::k0_uncached;
      linked_load_address_reg               <= 64'h0;
      move_rdata               <= 64'h0;
      order_reg                <= 1'b0;
      watch_exception          <= 1'b0;
      defer_reg                <= 1'b0;
    end
    else
    begin
      kernel_segment_coherency <= k0_next;
      linked_load_address_reg               <= linked_load_address_next;
      move_rdata               <= rdata_next;
      order_reg                <= byte_order_flag;
      watch_exception          <= exc_int;
      defer_reg                <= defer_int;
    end
  end

  assign deferred_flag = defer_reg;

  // ==========================================================
  // watch enables and deferral
  enable_mask #(
    .IMPL (WATCH_IMPL)
  ) u_enables (
    .clk     (clk),
    .resetn  (resetn),
    .we      (watch_we),
    .wdata   (move_req.wdata[cfg_pkg::wl_store_bit +: 3]),
    .enables (watch_en)
  );

  watch_defer u_defer (
    .clk                 (clk),
    .resetn              (resetn),
    .watch_hit           (watch_hit & HAS_WATCH),
    .exception_level_bit (exception_level_bit),
    .error_level_bit     (error_level_bit),
    .deferred_clear      (deferred_clear),
    .watch_exception     (exc_int),
    .deferred_flag       (defer_int)
  );
endmodule : core_config_capability_regs

// *** cfg_pkg.sv ***
// package: constants and types for the core configuration register bank
package cfg_pkg;

  // register numbers and selects on the system-control move port
  localparam logic [4:0] reg_num_config  = 5'h10;
  localparam logic [4:0] reg_num_linked_load_address  = 5'h11;
  localparam logic [4:0] reg_num_watch_address_low = 5'h12;
  localparam logic [2:0] sel_main        = 3'h0;
  localparam logic [2:0] sel_capability  = 3'h1;

  // main configuration field positions
  localparam int cfg_more_bit   = 31;
  localparam int cfg_order_bit  = 15;
  localparam int cfg_at_lsb     = 13;
  localparam int cfg_ar_lsb     = 10;
  localparam int cfg_mt_lsb     = 7;
  localparam int cfg_k0_lsb     = 0;
  localparam logic [2:0] k0_uncached = 3'h2;

  // capability field positions
  localparam int cap_tlb_lsb = 25;
  localparam int cap_is_lsb  = 22;
  localparam int cap_il_lsb  = 19;
  localparam int cap_ia_lsb  = 16;
  localparam int cap_ds_lsb  = 13;
  localparam int cap_dl_lsb  = 10;
  localparam int cap_da_lsb  = 7;
  localparam int cap_pc_bit  = 4;
  localparam int cap_wr_bit  = 3;
  localparam int cap_ca_bit  = 2;
  localparam int cap_ep_bit  = 1;
  localparam int cap_fp_bit  = 0;

  // watch enable positions
  localparam int wl_fetch_bit = 2;
  localparam int wl_load_bit  = 1;
  localparam int wl_store_bit = 0;

  localparam logic [2:0] mmu_none = 3'h0;

  // coprocessor move request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  num;
    logic [2:0]  sel;
    logic [63:0] wdata;
  } move_req_t;

  // watch deferral states, one-hot encoded
  typedef enum logic [1:0] {
    watch_idle     = 2'b01,
    watch_deferred = 2'b10
  } watch_state_t;

endpackage : cfg_pkg

// *** watch_defer.sv ***
// deferral of watch exceptions while exception or error level is set
`timescale 1ns/10ps
module watch_defer (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // status
  input  wire logic watch_hit,
  input  wire logic exception_level_bit,
  input  wire logic error_level_bit,
  input  wire logic deferred_clear,
  // results
  output logic      watch_exception,
  output logic      deferred_flag
);
  cfg_pkg::watch_state_t state_reg, state_next;
  logic exc_next;
  logic blocked;

  // ==========================================================
  // next state
  always_comb
  begin
    blocked   = exception_level_bit | error_level_bit;
    state_next = state_reg;
    exc_next   = 1'b0;
    case (state_reg)
      cfg_pkg::watch_idle:
      begin
        if (watch_hit && !blocked)
          exc_next = 1'b1;
        else if (watch_hit)
          state_next = cfg_pkg::watch_deferred;
      end
      cfg_pkg::watch_deferred:
      begin
        if (!blocked)
        begin
          exc_next   = 1'b1;
          state_next = cfg_pkg::watch_idle;
        end
        else if (deferred_clear && !watch_hit)
          state_next = cfg_pkg::watch_idle;
      end
      default: state_next = cfg_pkg::watch_idle;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg       <= cfg_pkg::watch_idle;
      watch_exception <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      watch_exception <= exc_next;
    end
  end

  assign deferred_flag = (state_reg == cfg_pkg::watch_deferred);
endmodule : watch_defer

// *** enable_mask.sv ***
// watch enable bits that keep only implemented reference types
`timescale 1ns/10ps
module enable_mask #(
  parameter logic [2:0] IMPL = 3'h7
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // write side
  input  wire logic       we,
  input  wire logic [2:0] wdata,
  // read side
  output logic [2:0]      enables
);
  logic [2:0] en_next;

  always_comb
  begin
    en_next = enables;
    if (we)
      en_next = wdata & IMPL;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      enables <= 3'h0;
    else
      enables <= en_next;
  end
endmodule : enable_mask

// *** cfg_regs_properties.sv ***
// checker: assertions on the configuration register bank ports
`timescale 1ns/10ps
module cfg_regs_properties #(
  parameter logic [1:0] ARCH_TYPE  = 2'h2,
  parameter logic [2:0] MMU_KIND   = 3'h1,
  parameter logic [2:0] WATCH_IMPL = 3'h3
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // watched ports
  input wire cfg_pkg::move_req_t move_req,
  input wire logic [63:0]        move_rdata,
  input wire logic               watch_hit,
  input wire logic               exception_level_bit,
  input wire logic               error_level_bit,
  input wire logic               watch_exception,
  input wire logic               deferred_flag,
  input wire logic [2:0]         kernel_segment_coherency
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // sequences
  sequence rd_at(logic [4:0] n, logic [2:0] s);
    move_req.rd && move_req.num == n && move_req.sel == s;
  endsequence
  sequence lv_high;
    exception_level_bit || error_level_bit;
  endsequence
  sequence hit_clear;
    watch_hit && !exception_level_bit && !error_level_bit
    ##1 !exception_level_bit && !error_level_bit;
  endsequence

  // ==========================================================
  // assertions
  main_fixed_a: assert property (rd_at(cfg_pkg::reg_num_config, cfg_pkg::sel_main) |=>
    move_rdata[31] && move_rdata[6:3] == 4'h0 && move_rdata[63:32] == 32'h0)
    else $error("main word fixed bits wrong");
  main_arch_a: assert property (rd_at(cfg_pkg::reg_num_config, cfg_pkg::sel_main) |=>
    move_rdata[14:13] == ARCH_TYPE && move_rdata[9:7] == MMU_KIND)
    else $error("main word preset fields wrong");
  main_k0_a: assert property (rd_at(cfg_pkg::reg_num_config, cfg_pkg::sel_main) |=>
    move_rdata[2:0] == $past(kernel_segment_coherency)) else $error("coherency read wrong");
  cap_rsvd_a: assert property (rd_at(cfg_pkg::reg_num_config, cfg_pkg::sel_capability) |=>
    !move_rdata[31] && move_rdata[6:5] == 2'h0) else $error("capability reserved bits set");
  k0_reset_a: assert property ($rose(resetn) |->
    kernel_segment_coherency == cfg_pkg::k0_uncached) else $error("coherency reset wrong");
  watch_take_a: assert property (hit_clear |=> watch_exception)
    else $error("watch exception not raised");
  watch_hold_a: assert property (lv_high [*3] |-> !watch_exception)
    else $error("watch exception while level set");
  defer_set_a: assert property (watch_hit && (exception_level_bit || error_level_bit)
    |-> ##2 deferred_flag) else $error("watch not deferred");
  wmask_a: assert property (move_req.rd && move_req.num == cfg_pkg::reg_num_watch_address_low |=>
    (move_rdata[2:0] & ~WATCH_IMPL) == 3'h0) else $error("unimplemented enable set");
endmodule : cfg_regs_properties

bind core_config_capability_regs cfg_regs_properties #(.ARCH_TYPE(ARCH_TYPE),
  .MMU_KIND(MMU_KIND), .WATCH_IMPL(WATCH_IMPL)) u_props (.clk(clk), .resetn(resetn),
  .move_req(move_req), .move_rdata(move_rdata), .watch_hit(watch_hit),
  .exception_level_bit(exception_level_bit), .error_level_bit(error_level_bit),
  .watch_exception(watch_exception), .deferred_flag(deferred_flag),
  .kernel_segment_coherency(kernel_segment_coherency));

// *** core_config_capability_regs_tb_top.sv ***
// testbench: random and corner checks of the configuration register bank
`timescale 1ns/10ps
module core_config_capability_regs_tb_top;
  localparam logic [1:0] AT = 2'h1;
  localparam logic [2:0] MT = 3'h0, IS = 3'h6, IL = 3'h1, IA = 3'h7, WI = 3'h5;
  logic clk, resetn, bo, llv, hit, el, rl, dclr, wexc, dflag;
  logic [63:0] rdata, llpa, d, v;
  logic [2:0] k0;
  cfg_pkg::move_req_t req;
  int num_errors, comparisons;

  core_config_capability_regs #(.ARCH_TYPE(AT), .MMU_KIND(MT), .ICACHE_SETS(IS),
    .ICACHE_LINE(IL), .ICACHE_WAYS(IA), .HAS_PERF(1'b1), .WATCH_IMPL(WI)) u_dut (
    .clk(clk), .resetn(resetn), .byte_order_flag(bo), .move_req(req), .move_rdata(rdata),
    .ll_valid(llv), .ll_paddr(llpa), .watch_hit(hit), .exception_level_bit(el),
    .error_level_bit(rl), .deferred_clear(dclr), .watch_exception(wexc),
    .deferred_flag(dflag), .kernel_segment_coherency(k0));

  // ==========================================================
  // helpers
  function automatic logic [63:0] main_word(logic b, logic [2:0] k);
    return {32'h0, 1'b1, 15'h0, b, AT, 3'h0, MT, 4'h0, k};
  endfunction : main_word

  // no memory management, so the tlb field reads zero
  function automatic logic [63:0] cap_word();
    return {32'h0, 1'b0, 6'h0, IS, IL, IA, 3'h2, 3'h4, 3'h1, 2'h0, 5'b11001};
  endfunction : cap_word

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic move(logic w, logic [4:0] n, logic [2:0] s, logic [63:0] wd);
    @(posedge clk);
    #1 req = '{wr: w, rd: !w, num: n, sel: s, wdata: wd};
    @(posedge clk);
    #1 d = rdata;
    req = '0;
  endtask : move

  task automatic hit_wait(logic exc);
    @(posedge clk);
    #1 hit = 1'b1;
    @(posedge clk);
    #1 hit = 1'b0;
    @(posedge clk);
    #1 check("watch_exception", {63'h0, wexc}, {63'h0, exc});
    check("deferred_flag", {63'h0, dflag}, {63'h0, !exc});
  endtask : hit_wait

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ==========================================================
  // clock, watchdog and sequence
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #400000;
    num_errors++;
    stop_test();
  end

  initial
  begin
    {resetn, bo, llv, hit, el, rl, dclr} = '0;
    req = '0;
    llpa = '0;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(21));
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    check("coherency", {61'h0, k0}, 64'h2);
    move(1'b0, 5'h10, 3'h0, '0);
    check("main", d, main_word(1'b0, 3'h2));
    for (int i = 0; i < 8; i++)
    begin
      v = {$urandom, $urandom};
      v[2:0] = i[2:0];
      bo = v[40];
      llpa = ~v;
      move(1'b1, 5'h10, 3'h0, v);
      move(1'b0, 5'h10, 3'h0, '0);
      check("main", d, main_word(bo, v[2:0]));
      check("coherency_out", {61'h0, k0}, {61'h0, v[2:0]});
      move(1'b1, 5'h10, 3'h1, v);
      move(1'b0, 5'h10, 3'h1, '0);
      check("capability", d, cap_word());
      @(posedge clk);
      #1 llv = 1'b1;
      @(posedge clk);
      #1 llv = 1'b0;
      move(1'b1, 5'h11, 3'h0, v);
      move(1'b0, 5'h11, 3'h0, '0);
      check("linked_load_address", d, ~v);
      move(1'b1, 5'h12, 3'h0, v);
      move(1'b0, 5'h12, 3'h0, '0);
      check("watch_enables", d, {61'h0, v[2:0] & WI});
    end
    move(1'b0, 5'h05, 3'h0, '0);
    check("unmapped", d, 64'h0);
    hit_wait(1'b1);
    el = 1'b1;
    hit_wait(1'b0);
    dclr = 1'b1;
    @(posedge clk);
    #1 dclr = 1'b0;
    // the flag output is one register behind the deferral state
    @(posedge clk);
    #1 check("deferred_clear", {63'h0, dflag}, 64'h0);
    el = 1'b0;
    rl = 1'b1;
    hit_wait(1'b0);
    rl = 1'b0;
    v = '0;
    repeat (4)
    begin
      @(posedge clk);
      #1 v[0] = v[0] | wexc;
    end
    check("deferred_release", v, 64'h1);
    check("deferred_flag_release", {63'h0, dflag}, 64'h0);
    stop_test();
  end
endmodule : core_config_capability_regs_tb_top
